// ===== wakeup_filter_pkg.sv
// What this block does
// - load checksum with all ones at frame start
// - checksum advances only on selected bytes
// - eight chained terms per selected byte
// - new bits 14 to 10 from old bits
// - new bits 7 to 0 from terms
// - pattern offset zero is first destination byte
// - broadcast, multicast, address match and filter enables
// - detection only while wake frame enable set
// - irq mask bit 8 gates wake event
// - match sets received flag and triggered flag
// - mask bit j selects byte offset plus j
// - wake only in five address cases
// - match needs good frame check and checksum
package wakeup_filter_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_WAKE_CTRL   = 8'h00;  // wakeup_ctrl_status
  localparam logic [7:0] ADDR_CFG_A       = 8'h04;  // filter_config_a
  localparam logic [7:0] ADDR_CFG_B       = 8'h08;  // filter_config_b
  localparam logic [7:0] ADDR_MASK0       = 8'h0C;  // filter_byte_mask words 0..3
  localparam logic [7:0] ADDR_MASK3       = 8'h18;
  localparam logic [7:0] ADDR_MAC_LO      = 8'h1C;  // wake_mac_addr_lo
  localparam logic [7:0] ADDR_MAC_MID     = 8'h20;  // wake_mac_addr_mid
  localparam logic [7:0] ADDR_MAC_HI      = 8'h24;  // wake_mac_addr_hi
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h28;  // irq source flags
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h2C;  // phy_irq_mask

  // wakeup_ctrl_status fields
  localparam int WAKE_EN_BIT   = 0;  // wake_frame_enable
  localparam int WAKE_RCVD_BIT = 1;  // wake_frame_received, write one to clear

  // filter_config_a fields
  localparam int CFGA_OFFSET_LSB  = 0;   // pattern offset
  localparam int CFGA_OFFSET_W    = 8;
  localparam int CFGA_ADDR_EN_BIT = 24;  // address match enable
  localparam int CFGA_MCAST_BIT   = 25;  // any multicast enable
  localparam int CFGA_BCAST_BIT   = 26;  // broadcast enable
  localparam int CFGA_TRIG_BIT    = 30;  // filter triggered, write one to clear
  localparam int CFGA_EN_BIT      = 31;  // filter enable

  // interrupt bit of the wake event
  localparam int IRQ_WOL_BIT = 8;

  // widths and values
  localparam int          CRC_W     = 16;
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam int          MASK_BITS = 128;
  localparam int          MAC_BYTES = 6;
  localparam int          CNT_W     = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// ===== wakeup_frame_crc_filter.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns
module wakeup_frame_crc_filter #(
  parameter int OFFSET_W = wakeup_filter_pkg::CFGA_OFFSET_W  // pattern offset width
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // receive byte stream
  input  wire logic        rxStart,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxEnd,
  input  wire logic        rxFrameOk,
  // wake interrupt
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // one byte step of the running checksum
  // data bit 0 enters first, the order in which bits leave the wire
  // the terms chain, so each one folds in all lower data bits
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    logic [7:0]  t;
    logic [15:0] n;
    t[0] = c[15] ^ d[0];
    for (int k = 1; k < 8; k++) begin
      t[k] = c[15-k] ^ t[k-1] ^ d[k];
    end
    n[15] = c[7] ^ t[7];
    n[14:10] = c[6:2];
    n[9] = c[1] ^ t[0];
    n[8] = c[0] ^ t[1];
    for (int b = 2; b < 8; b++) begin
      n[b] = t[7-b] ^ t[9-b];
    end
    n[1] = t[6];
    n[0] = t[7];
    return n;
  endfunction

  // apply a write-one-to-clear with the hardware set winning
  // shared by all three sticky flags
  function automatic logic stickyNext(input logic q, input logic clr, input logic set);
    return (q & ~clr) | set;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic                wakeEn_q;         // wake_frame_enable
  logic                wakeRcvd_q;       // wake_frame_received
  logic [OFFSET_W-1:0] patOffset_q;      // pattern offset
  logic                addrEn_q;         // address match enable
  logic                mcastEn_q;        // any multicast enable
  logic                bcastEn_q;        // broadcast enable
  logic                filtEn_q;         // filter enable
  logic                filtTrig_q;       // filter triggered
  logic [15:0]         expCrc_q;         // expected checksum
  // the 128-bit mask is small enough to sit in flops, no memory macro
  logic [31:0]         maskWord_q [4];   // filter_byte_mask words
  logic [15:0]         macLo_q;          // bytes 0 and 1 of the wake address
  logic [15:0]         macMid_q;         // bytes 2 and 3
  logic [15:0]         macHi_q;          // bytes 4 and 5
  logic                irqStat_q;        // wake event source flag
  logic                irqMask_q;        // wake event mask

  // apb output flops
  logic [31:0]         prdata_q;
  logic                pready_q;
  logic                pslverr_q;
  logic                irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // frame tracking state
  // these restart at every rxStart, so a cut frame leaves nothing behind

  logic [15:0]         crc_q;            // running checksum
  logic [15:0]         crc_d;
  logic [15:0]         byteCnt_q;        // frame byte index, saturates
  logic                inFrame_q;        // between start and end
  logic                daBcast_q;        // destination all ones so far
  logic                daMatch_q;        // destination equals wake address so far
  logic                daMcast_q;        // group bit of first destination byte

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  // every transfer completes in its first access cycle; no wait states
  // unmapped addresses decode to nothing, so a write there changes no state
  wire setupPhase  = psel & ~penable;                 // first cycle of a transfer
  wire accessDone  = psel & penable & pready_q;       // completing cycle
  wire wrDone      = accessDone & pwrite;             // write takes effect here
  wire selCtrl     = (paddr == wakeup_filter_pkg::ADDR_WAKE_CTRL);
  wire selCfgA     = (paddr == wakeup_filter_pkg::ADDR_CFG_A);
  wire selCfgB     = (paddr == wakeup_filter_pkg::ADDR_CFG_B);
  wire selMask     = (paddr >= wakeup_filter_pkg::ADDR_MASK0) &&
                     (paddr <= wakeup_filter_pkg::ADDR_MASK3) && (paddr[1:0] == 2'b00);
  wire selMacLo    = (paddr == wakeup_filter_pkg::ADDR_MAC_LO);
  wire selMacMid   = (paddr == wakeup_filter_pkg::ADDR_MAC_MID);
  wire selMacHi    = (paddr == wakeup_filter_pkg::ADDR_MAC_HI);
  wire selIrqStat  = (paddr == wakeup_filter_pkg::ADDR_IRQ_STATUS);
  wire selIrqMask  = (paddr == wakeup_filter_pkg::ADDR_IRQ_MASK);
  wire mapped      = selCtrl | selCfgA | selCfgB | selMask | selMacLo | selMacMid |
                     selMacHi | selIrqStat | selIrqMask;
  wire [7:0] maskOfs = paddr - wakeup_filter_pkg::ADDR_MASK0;
  wire [1:0] maskIdx = maskOfs[3:2];                  // which mask word

  // read data assembly, if and else-if chain per address
  logic [31:0] rdMux;
  always_comb begin
    rdMux = wakeup_filter_pkg::RESET_WORD;
    if (selCtrl) begin
      rdMux[wakeup_filter_pkg::WAKE_EN_BIT]   = wakeEn_q;
      rdMux[wakeup_filter_pkg::WAKE_RCVD_BIT] = wakeRcvd_q;
    end else if (selCfgA) begin
      rdMux[wakeup_filter_pkg::CFGA_OFFSET_LSB +: OFFSET_W] = patOffset_q;
      rdMux[wakeup_filter_pkg::CFGA_ADDR_EN_BIT] = addrEn_q;
      rdMux[wakeup_filter_pkg::CFGA_MCAST_BIT]   = mcastEn_q;
      rdMux[wakeup_filter_pkg::CFGA_BCAST_BIT]   = bcastEn_q;
      rdMux[wakeup_filter_pkg::CFGA_TRIG_BIT]    = filtTrig_q;
      rdMux[wakeup_filter_pkg::CFGA_EN_BIT]      = filtEn_q;
    end else if (selCfgB) begin
      rdMux[15:0] = expCrc_q;
    end else if (selMask) begin
      rdMux = maskWord_q[maskIdx];
    end else if (selMacLo) begin
      rdMux[15:0] = macLo_q;
    end else if (selMacMid) begin
      rdMux[15:0] = macMid_q;
    end else if (selMacHi) begin
      rdMux[15:0] = macHi_q;
    end else if (selIrqStat) begin
      rdMux[wakeup_filter_pkg::IRQ_WOL_BIT] = irqStat_q;
    end else if (selIrqMask) begin
      rdMux[wakeup_filter_pkg::IRQ_WOL_BIT] = irqMask_q;
    end
  end

  // apb answer: one wait-free access phase, data sampled in setup
  // read data is captured in setup so it stands through the access cycle
  // trade-off: zero wait states means every read source must settle in one cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata_q  <= wakeup_filter_pkg::RESET_WORD;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setupPhase;
      pslverr_q <= setupPhase & ~mapped;   // unmapped address errors
      if (setupPhase) begin
        prdata_q <= rdMux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame byte selection and address checks
  // bytes before the offset or past the 128-byte window never touch the checksum
  // limitation: the byte index saturates, so only the first 64k bytes are seen

  wire [15:0] offsetExt = {{(16-OFFSET_W){1'b0}}, patOffset_q};
  wire [15:0] relIdx    = byteCnt_q - offsetExt;       // index into the byte mask
  wire        inWindow  = (byteCnt_q >= offsetExt) &&
                          (relIdx < 16'(wakeup_filter_pkg::MASK_BITS));
  wire        maskBit   = maskWord_q[relIdx[6:5]][relIdx[4:0]];
  wire        takeByte  = inFrame_q & rxValid & inWindow & maskBit;
  wire        daByte    = inFrame_q & rxValid &
                          (byteCnt_q < 16'(wakeup_filter_pkg::MAC_BYTES));
  wire [47:0] macAll    = {macHi_q, macMid_q, macLo_q};  // byte 0 in bits 7:0
  wire [7:0]  macByte   = macAll[byteCnt_q[2:0]*8 +: 8];
  wire        daLong    = (byteCnt_q >= 16'(wakeup_filter_pkg::MAC_BYTES));

  // checksum next value
  // unselected bytes and idle gaps leave the value alone
  always_comb begin
    crc_d = crc_q;
    if (rxStart) begin
      crc_d = wakeup_filter_pkg::CRC_INIT;
    end else if (takeByte) begin
      crc_d = crcStep(crc_q, rxData);
    end
  end

  // frame trackers; a new start always restarts the checksum
  // rxStart wins over rxEnd and rxValid arriving in the same cycle
  // trade-off: the address is compared byte by byte, so no destination is stored
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      crc_q     <= wakeup_filter_pkg::CRC_INIT;
      byteCnt_q <= 16'h0000;
      inFrame_q <= 1'b0;
      daBcast_q <= 1'b0;
      daMatch_q <= 1'b0;
      daMcast_q <= 1'b0;
    end else begin
      crc_q <= crc_d;
      if (rxStart) begin
        byteCnt_q <= 16'h0000;
        inFrame_q <= 1'b1;
        daBcast_q <= 1'b1;
        daMatch_q <= 1'b1;
        daMcast_q <= 1'b0;
      end else begin
        if (rxEnd) begin
          inFrame_q <= 1'b0;
        end
        if (inFrame_q & rxValid & (byteCnt_q != 16'hFFFF)) begin
          byteCnt_q <= byteCnt_q + 16'h0001;  // saturate on huge frames
        end
        if (daByte) begin
          daBcast_q <= daBcast_q & (rxData == 8'hFF);
          daMatch_q <= daMatch_q & (rxData == macByte);
          if (byteCnt_q == 16'h0000) begin
            daMcast_q <= rxData[0];
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wake decision at end of frame

  // the destination class is only known once six bytes have passed
  // a broadcast also has the group bit set; it is classed as broadcast only
  // a frame too short to hold a full destination counts as a unicast without an address hit
  wire isBcast   = daLong & daBcast_q;
  wire isMcast   = daLong & daMcast_q & ~daBcast_q;
  wire addrHit   = daLong & daMatch_q;
  wire addrOk    = isBcast ? bcastEn_q :
                   isMcast ? (mcastEn_q | (addrEn_q & addrHit)) :
                   (~addrEn_q | addrHit);
  wire crcOk     = (crc_q == expCrc_q);
  wire frameDone = inFrame_q & rxEnd & ~rxStart;
  wire wakeHit   = frameDone & rxFrameOk & crcOk & addrOk &
                   filtEn_q & wakeEn_q;

  //////////////////////////////////////////////////////////////////////////////
  // register writes and sticky flags

  wire [31:0] wd      = pwdata;
  wire        wrCtrl  = wrDone & selCtrl;
  wire        wrCfgA  = wrDone & selCfgA;
  wire        wrIrqS  = wrDone & selIrqStat;
  wire        wrIrqM  = wrDone & selIrqMask;

  // next wake source flag and mask; the irq flop takes both so that a mask or
  // clear write moves irq on the same edge as the register it changes
  // without this, irq would lag a mask write by one cycle
  wire        irqStatNext = stickyNext(irqStat_q,
                                       wrIrqS & wd[wakeup_filter_pkg::IRQ_WOL_BIT], wakeHit);
  wire        irqMaskNext = wrIrqM ? wd[wakeup_filter_pkg::IRQ_WOL_BIT] : irqMask_q;

  // configuration registers written by software
  // reserved bits are dropped on write and read back as zero
  // software sets the enables last, so a half-built filter never fires
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wakeEn_q    <= 1'b0;
      patOffset_q <= '0;
      addrEn_q    <= 1'b0;
      mcastEn_q   <= 1'b0;
      bcastEn_q   <= 1'b0;
      filtEn_q    <= 1'b0;
      expCrc_q    <= 16'h0000;
      macLo_q     <= 16'h0000;
      macMid_q    <= 16'h0000;
      macHi_q     <= 16'h0000;
      irqMask_q   <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        maskWord_q[i] <= 32'h0000_0000;
      end
    end else begin
      if (wrCtrl) begin
        wakeEn_q <= wd[wakeup_filter_pkg::WAKE_EN_BIT];
      end
      if (wrCfgA) begin
        patOffset_q <= wd[wakeup_filter_pkg::CFGA_OFFSET_LSB +: OFFSET_W];
        addrEn_q    <= wd[wakeup_filter_pkg::CFGA_ADDR_EN_BIT];
        mcastEn_q   <= wd[wakeup_filter_pkg::CFGA_MCAST_BIT];
        bcastEn_q   <= wd[wakeup_filter_pkg::CFGA_BCAST_BIT];
        filtEn_q    <= wd[wakeup_filter_pkg::CFGA_EN_BIT];
      end
      if (wrDone & selCfgB) begin
        expCrc_q <= wd[15:0];
      end
      if (wrDone & selMask) begin
        maskWord_q[maskIdx] <= wd;
      end
      if (wrDone & selMacLo) begin
        macLo_q <= wd[15:0];
      end
      if (wrDone & selMacMid) begin
        macMid_q <= wd[15:0];
      end
      if (wrDone & selMacHi) begin
        macHi_q <= wd[15:0];
      end
      if (wrDone & selIrqMask) begin
        irqMask_q <= wd[wakeup_filter_pkg::IRQ_WOL_BIT];
      end
    end
  end

  // sticky flags: a hit in the clearing cycle still sets the flag
  // a clear in the same cycle as a hit loses, so no wake event is missed
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wakeRcvd_q <= 1'b0;
      filtTrig_q <= 1'b0;
      irqStat_q  <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      wakeRcvd_q <= stickyNext(wakeRcvd_q,
                               wrCtrl & wd[wakeup_filter_pkg::WAKE_RCVD_BIT], wakeHit);
      filtTrig_q <= stickyNext(filtTrig_q,
                               wrCfgA & wd[wakeup_filter_pkg::CFGA_TRIG_BIT], wakeHit);
      irqStat_q  <= irqStatNext;
      irq_q      <= irqStatNext & irqMaskNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  // nothing combinational reaches a pin, so timing at the boundary is clean

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

endmodule

// ===== rx_frame_source.sv
`timescale 1ns/1ns
// model of the receive datapath that feeds frame bytes
module rx_frame_source (
  input  wire logic       clk_sys,
  output logic            rxStart,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            rxEnd,
  output logic            rxFrameOk
);
  logic [7:0] frm [64];  // frame bytes, loaded by the bench

  // idle state at time zero
  initial begin
    rxStart = 1'b0;
    rxValid = 1'b0;
    rxEnd = 1'b0;
    rxFrameOk = 1'b0;
    rxData = 8'hA5;
  end

  ////////////////////////////////////////
  // one frame: start, bytes with gap idle cycles, end with status
  task automatic send(input int len, input logic ok, input int gap);
    rxStart <= 1'b1;
    @(posedge clk_sys);
    rxStart <= 1'b0;
    for (int i = 0; i < len; i++) begin
      rxValid <= 1'b1;
      rxData <= frm[i];
      @(posedge clk_sys);
      // data goes stale between bytes, never repeats the last one
      if (gap > 0) begin
        rxValid <= 1'b0;
        rxData <= ~frm[i];
        repeat (gap) @(posedge clk_sys);
      end
    end
    rxValid <= 1'b0;
    rxData <= ~frm[len-1];
    rxEnd <= 1'b1;
    rxFrameOk <= ok;
    @(posedge clk_sys);
    rxEnd <= 1'b0;
    rxFrameOk <= ~ok;
  endtask
endmodule

// ===== wakeup_frame_crc_filter_properties.sv
`timescale 1ns/1ns
module wakeup_filter_checker #(
  parameter int OFFSET_W = 8
) (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxStart,
  input wire logic        rxValid,
  input wire logic [7:0]  rxData,
  input wire logic        rxEnd,
  input wire logic        rxFrameOk,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////
  // write strobes at the access edge
  wire regWr = psel && penable && pwrite;
  wire mskWr = regWr && paddr == wakeup_filter_pkg::ADDR_IRQ_MASK;
  wire stsWr = regWr && paddr == wakeup_filter_pkg::ADDR_IRQ_STATUS;

  ////////////////////////////////////////
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside a single access cycle");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h2C |=> pslverr)
    else $error("unmapped access without error");
  a_irq_held: assert property (!rxEnd && !regWr |=> $stable(irq))
    else $error("irq moved without cause");
  a_bad_frame_quiet: assert property (rxEnd && !rxFrameOk && !irq && !regWr |=> !irq)
    else $error("irq from a bad frame");
  a_rise_has_cause: assert property ($rose(irq) |-> $past(rxFrameOk) || $past(regWr))
    else $error("irq rose without good frame or write");
  a_mask_gates: assert property (mskWr && !pwdata[8] |=> !irq)
    else $error("irq high with mask bit clear");
  a_clear_drops: assert property (stsWr && pwdata[8] && !rxEnd |=> !irq)
    else $error("irq stayed after clear");
endmodule

bind wakeup_frame_crc_filter wakeup_filter_checker #(.OFFSET_W(OFFSET_W)) chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxStart(rxStart), .rxValid(rxValid),
  .rxData(rxData), .rxEnd(rxEnd), .rxFrameOk(rxFrameOk), .irq(irq)
);

// ===== test_wakeup_frame_crc_filter.sv
`timescale 1ns/1ns
module test_wakeup_frame_crc_filter;
  logic        clk_sys, reset_n;           // clock and sync reset
  logic        psel, penable, pwrite;      // apb request
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;        // rdv: last read word
  logic        pready, pslverr, irq, rde;  // rde: last error flag
  logic        rxStart, rxValid, rxEnd, rxFrameOk;
  logic [7:0]  rxData;
  int          fails, n_tests;
  logic [31:0] seed;                       // xorshift state

  wakeup_frame_crc_filter uut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxStart(rxStart), .rxValid(rxValid),
    .rxData(rxData), .rxEnd(rxEnd), .rxFrameOk(rxFrameOk), .irq(irq));
  rx_frame_source src (.clk_sys(clk_sys), .rxStart(rxStart), .rxValid(rxValid),
    .rxData(rxData), .rxEnd(rxEnd), .rxFrameOk(rxFrameOk));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////
  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // one byte of the checksum, bit 0 of the data first
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    logic [7:0] f;
    f[0] = c[15] ^ d[0];
    for (int k = 1; k < 8; k++) f[k] = c[15-k] ^ f[k-1] ^ d[k];
    return {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], f[0] ^ f[2], f[1] ^ f[3],
            f[2] ^ f[4], f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
  endfunction

  // apb transfer; waits for pready with a bound, a hang ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);  // idle edge: psel is never assigned twice in one step
  endtask

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rdv & m, exp);
  endtask

  ////////////////////////////////////////
  initial begin
    logic [31:0]  w;
    logic [127:0] mk;
    logic [47:0]  mac, dst;
    logic [15:0]  c;
    logic         wake, bc, mc;
    int           len, off;
    seed = 32'h0001_5130;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset_n = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    // reset values, unmapped word, reserved bits
    for (int a = 0; a < 48; a += 4) rdChk("reset word", 8'(a), 32'hFFFF_FFFF, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check("unmapped data", rdv, 32'h0);
    check("unmapped error", {31'h0, rde}, 32'h1);
    apb(1'b1, wakeup_filter_pkg::ADDR_CFG_A, 32'hFFFF_FFFF);
    rdChk("cfg a fields", wakeup_filter_pkg::ADDR_CFG_A, 32'hFFFF_FFFF, 32'h8700_00FF);
    check("mapped error", {31'h0, rde}, 32'h0);
    // random frames with random filter settings
    for (int t = 0; t < 60; t++) begin
      w = rnd();
      mk = {rnd(), rnd(), rnd(), rnd()};
      len = 20 + int'(w[31:28]);
      off = int'(w[27:24]);
      for (int i = 0; i < len; i++) src.frm[i] = 8'(rnd());
      if (w[16:15] == 2'h2) for (int i = 0; i < 6; i++) src.frm[i] = 8'hFF;
      else src.frm[0][0] = (w[16:15] == 2'h1);
      dst = {src.frm[5], src.frm[4], src.frm[3], src.frm[2], src.frm[1], src.frm[0]};
      mac = w[17] ? dst : 48'({rnd(), rnd()});
      bc = &dst;
      mc = dst[0] && !bc;
      c = wakeup_filter_pkg::CRC_INIT;
      for (int i = off; i < len && i - off < 128; i++)
        if (mk[i-off]) c = crcStep(c, src.frm[i]);
      wake = w[10:8] != 0 && w[7:5] != 0 && w[4:2] != 0 && w[1:0] != 0 &&
             ((!mc && !bc && (!w[11] || mac == dst)) || (mc && (w[12] || (w[11] && mac == dst)))
             || (bc && w[13]));
      // host order: mask, checksum, address, offset, then enables
      for (int k = 0; k < 4; k++)
        apb(1'b1, wakeup_filter_pkg::ADDR_MASK0 + 8'(4 * k), mk[32*k +: 32]);
      apb(1'b1, wakeup_filter_pkg::ADDR_CFG_B, {16'h0, c ^ (w[1:0] != 0 ? 16'h0 : 16'h1 << w[23:20])});
      apb(1'b1, wakeup_filter_pkg::ADDR_MAC_LO, {16'h0, mac[15:0]});
      apb(1'b1, wakeup_filter_pkg::ADDR_MAC_MID, {16'h0, mac[31:16]});
      apb(1'b1, wakeup_filter_pkg::ADDR_MAC_HI, {16'h0, mac[47:32]});
      apb(1'b1, wakeup_filter_pkg::ADDR_CFG_A, {5'h0, w[13:11], 16'h0, 8'(off)});
      apb(1'b1, wakeup_filter_pkg::ADDR_CFG_A, {w[10:8] != 0, 4'h0, w[13:11], 16'h0, 8'(off)});
      apb(1'b1, wakeup_filter_pkg::ADDR_IRQ_MASK, {23'h0, w[14], 8'h0});
      apb(1'b1, wakeup_filter_pkg::ADDR_WAKE_CTRL, {31'h0, w[7:5] != 0});
      src.send(len, w[4:2] != 0, int'(w[19:18]));
      rdChk("wake ctrl", wakeup_filter_pkg::ADDR_WAKE_CTRL, 32'h3, {wake, w[7:5] != 0});
      rdChk("triggered", wakeup_filter_pkg::ADDR_CFG_A, 32'h4000_0000, {1'b0, wake, 30'h0});
      rdChk("irq source", wakeup_filter_pkg::ADDR_IRQ_STATUS, 32'h100, {wake, 8'h0});
      check("irq level", irq, wake && w[14]);
      if (wake && !w[14]) begin
        apb(1'b1, wakeup_filter_pkg::ADDR_IRQ_MASK, 32'h100);
        repeat (2) @(posedge clk_sys);
        check("irq unmasked", irq, 32'h1);
      end
      // write one to clear every sticky flag
      apb(1'b1, wakeup_filter_pkg::ADDR_WAKE_CTRL, 32'h2);
      apb(1'b1, wakeup_filter_pkg::ADDR_CFG_A, 32'h4000_0000);
      apb(1'b1, wakeup_filter_pkg::ADDR_IRQ_STATUS, 32'h100);
      repeat (2) @(posedge clk_sys);
      check("irq cleared", irq, 32'h0);
      rdChk("flags cleared", wakeup_filter_pkg::ADDR_WAKE_CTRL, 32'h3, 32'h0);
    end
    report_and_stop();
  end
endmodule
